// ### core/mdbgc_top.sv
// monitor debug, abort record, clock enable qualification and test clock sync
// assumes a classic wishbone master and an off-chip agent waiting on return
`timescale 1ns/10ps
`default_nettype none
module mdbgc_top (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic TEST_CLK,
	output logic RETURNED_TEST_CLOCK,
	output logic DEBUG_CLOCK_ENABLE,
	input wire logic SYSTEM_CLOCK_ENABLE,
	output logic CORE_CLOCK_ENABLE,
	input wire logic EXTERNAL_DEBUG_REQUEST,
	input wire logic EXTERNAL_BREAKPOINT_INPUT,
	input wire logic EXTERNAL_WATCHPOINT_INPUT,
	input wire logic EXTERNAL_WATCH_CONDITIONER,
	input wire logic INSTR_VALID,
	input wire logic [31:0] INSTR_ADDR,
	input wire logic INSTR_PRIVILEGE_INDICATOR,
	input wire logic INSTR_WIDTH_INDICATOR,
	input wire logic DATA_VALID,
	input wire logic [31:0] DATA_ADDR,
	input wire logic DATA_WRITE,
	input wire logic [1:0] DATA_ACCESS_SIZE,
	input wire logic DATA_PRIVILEGE_INDICATOR,
	input wire logic DATA_VALUE_MATCH,
	input wire logic STEP_DONE,
	input wire logic FORCED_MULTIPLE,
	input wire logic CORE_EXIT_DEBUG,
	input wire logic MEM_ABORT_IN,
	input wire logic IRQ_IN,
	output logic PREFETCH_ABORT,
	output logic DATA_ABORT,
	output logic DEBUG_ACK,
	output logic MEM_IDLE,
	output logic FORCED_ACCEPT,
	output logic ABORT_TAKE,
	output logic IRQ_TAKE
);
	import mdbgc_pkg::*;
	logic rst_meta_ff, rst_n;
	default clocking cb_core @(posedge CORE_CLK); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	// test clock synchronizer and edge pulse
	logic [SYNC_STAGES-1:0] tck_ff, nxt_tck;
	logic tck_last_ff, nxt_tck_last, den_ff, nxt_den;
	always_comb begin
		nxt_tck = {tck_ff[SYNC_STAGES-2:0], TEST_CLK};
		nxt_den = 1'b0;
		if ((tck_ff[1] == tck_ff[2]) && (tck_ff[2] != tck_last_ff))
			nxt_tck_last = tck_ff[2];
		else
			nxt_tck_last = tck_last_ff;
		if ((tck_ff[1] == tck_ff[2]) && tck_ff[2] && !tck_last_ff)
			nxt_den = 1'b1;
	end
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tck_ff <= '0;
			tck_last_ff <= 1'b0;
			den_ff <= 1'b0;
		end else begin
			tck_ff <= nxt_tck;
			tck_last_ff <= nxt_tck_last;
			den_ff <= nxt_den;
		end
	end
	logic returned_test_clock_ff, nxt_returned_test_clock;
	always_comb nxt_returned_test_clock = tck_last_ff;
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n)
			returned_test_clock_ff <= 1'b0;
		else
			returned_test_clock_ff <= nxt_returned_test_clock;
	end

	// registers
	logic [31:0] ctrl_ff, nxt_ctrl, wpc_ff, nxt_wpc, wpa_ff, nxt_wpa;
	logic [31:0] wpm_ff, nxt_wpm, bpa_ff, nxt_bpa, bpc_ff, nxt_bpc;
	logic [31:0] rdat_ff, nxt_rdat;
	logic ack_ff, nxt_ack, abort_rec_ff, nxt_abort_rec, width_ff, nxt_width;
	logic wp_upd, bp_upd, wr, rd_req;
	logic bp_hit, wp_hit, monitor;
	mdbgc_state_t state_ff, nxt_state;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	always_comb begin
		wr = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_ff;
		rd_req = WB_CYC_I && WB_STB_I && !ack_ff;
		nxt_ack = rd_req;
		nxt_ctrl = ctrl_ff;
		nxt_wpc = wpc_ff;
		nxt_wpa = wpa_ff;
		nxt_wpm = wpm_ff;
		nxt_bpa = bpa_ff;
		nxt_bpc = bpc_ff;
		nxt_rdat = rdat_ff;
		wp_upd = 1'b0;
		bp_upd = 1'b0;
		if (wr) begin
			case (WB_ADR_I)
				ADDR_DBG_CTRL: nxt_ctrl = merge(ctrl_ff, WB_DAT_I, WB_SEL_I);
				ADDR_WP_CTRL: begin
					nxt_wpc = merge(wpc_ff, WB_DAT_I, WB_SEL_I);
					wp_upd = 1'b1;
				end
				ADDR_WP_ADDR: begin
					nxt_wpa = merge(wpa_ff, WB_DAT_I, WB_SEL_I);
					wp_upd = 1'b1;
				end
				ADDR_WP_MASK: begin
					nxt_wpm = merge(wpm_ff, WB_DAT_I, WB_SEL_I);
					wp_upd = 1'b1;
				end
				ADDR_BP_ADDR: begin
					nxt_bpa = merge(bpa_ff, WB_DAT_I, WB_SEL_I);
					bp_upd = 1'b1;
				end
				ADDR_BP_CTRL: begin
					nxt_bpc = merge(bpc_ff, WB_DAT_I, WB_SEL_I);
					bp_upd = 1'b1;
				end
				default: nxt_ctrl = ctrl_ff;
			endcase
		end
		if (rd_req) begin
			case (WB_ADR_I)
				ADDR_DBG_CTRL: nxt_rdat = ctrl_ff;
				ADDR_DBG_STAT: nxt_rdat = {27'h0, width_ff, 2'h0,
					(state_ff == MDBGC_HALT), abort_rec_ff};
				ADDR_WP_CTRL: nxt_rdat = wpc_ff;
				ADDR_WP_ADDR: nxt_rdat = wpa_ff;
				ADDR_WP_MASK: nxt_rdat = wpm_ff;
				ADDR_BP_ADDR: nxt_rdat = bpa_ff;
				ADDR_BP_CTRL: nxt_rdat = bpc_ff;
				default: nxt_rdat = UNMAPPED_READ;
			endcase
		end
	end

	assign monitor = ctrl_ff[CTRL_RT_BIT];

	mdbgc_watch_unit u_bp (
		.clk(CORE_CLK),
		.rst_n(rst_n),
		.ctrl(bpc_ff),
		.addr_val(bpa_ff),
		.addr_mask(32'h0000_0000),
		.monitor(monitor),
		.reg_update(bp_upd),
		.access_valid(INSTR_VALID),
		.access_addr(INSTR_ADDR),
		.access_write(1'b0),
		.access_size({1'b0, INSTR_WIDTH_INDICATOR}),
		.access_priv(INSTR_PRIVILEGE_INDICATOR),
		.conditioner(EXTERNAL_WATCH_CONDITIONER),
		.data_match(1'b1),
		.hit(bp_hit)
	);
	mdbgc_watch_unit u_wp (
		.clk(CORE_CLK),
		.rst_n(rst_n),
		.ctrl(wpc_ff),
		.addr_val(wpa_ff),
		.addr_mask(monitor ? 32'h0000_0000 : wpm_ff),
		.monitor(monitor),
		.reg_update(wp_upd),
		.access_valid(DATA_VALID),
		.access_addr(DATA_ADDR),
		.access_write(DATA_WRITE),
		.access_size(DATA_ACCESS_SIZE),
		.access_priv(DATA_PRIVILEGE_INDICATOR),
		.conditioner(EXTERNAL_WATCH_CONDITIONER),
		.data_match(DATA_VALUE_MATCH),
		.hit(wp_hit)
	);

	// debug state, aborts and abort record
	logic pabt_ff, nxt_pabt, dabt_ff, nxt_dabt, bp_ev, wp_ev, step_ev;
	always_comb begin
		bp_ev = bp_hit || (!monitor && ctrl_ff[CTRL_XEN_BIT] && EXTERNAL_BREAKPOINT_INPUT);
		wp_ev = wp_hit || (!monitor && ctrl_ff[CTRL_XEN_BIT] && EXTERNAL_WATCHPOINT_INPUT);
		step_ev = !monitor && ctrl_ff[CTRL_STEP_BIT] && STEP_DONE;
		nxt_state = state_ff;
		nxt_pabt = 1'b0;
		nxt_dabt = 1'b0;
		nxt_width = width_ff;
		nxt_abort_rec = abort_rec_ff;
		if (wr && (WB_ADR_I == ADDR_DBG_STAT) && WB_SEL_I[0] && WB_DAT_I[STAT_ABORT_BIT])
			nxt_abort_rec = 1'b0;
		case (state_ff)
			MDBGC_RUN: begin
				if (monitor) begin
					nxt_pabt = bp_ev;
					nxt_dabt = wp_ev && !bp_ev;
					if (bp_ev || wp_ev)
						nxt_abort_rec = 1'b1;
				end else if (bp_ev || wp_ev || step_ev || EXTERNAL_DEBUG_REQUEST) begin
					nxt_state = MDBGC_HALT;
					nxt_width = INSTR_WIDTH_INDICATOR;
				end
			end
			MDBGC_HALT: begin
				if (CORE_EXIT_DEBUG)
					nxt_state = MDBGC_RUN;
			end
			default: nxt_state = MDBGC_RUN;
		endcase
	end

	logic ack_o_ff, cen_ff, nxt_cen, idle_ff, fa_ff, at_ff, it_ff;
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= RST_ZERO;
			wpc_ff <= RST_ZERO;
			wpa_ff <= RST_ZERO;
			wpm_ff <= RST_ZERO;
			bpa_ff <= RST_ZERO;
			bpc_ff <= RST_ZERO;
			rdat_ff <= RST_ZERO;
			ack_ff <= 1'b0;
			abort_rec_ff <= 1'b0;
			width_ff <= 1'b0;
			state_ff <= MDBGC_RUN;
			pabt_ff <= 1'b0;
			dabt_ff <= 1'b0;
			cen_ff <= 1'b0;
			idle_ff <= 1'b0;
			fa_ff <= 1'b0;
			at_ff <= 1'b0;
			it_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			wpc_ff <= nxt_wpc;
			wpa_ff <= nxt_wpa;
			wpm_ff <= nxt_wpm;
			bpa_ff <= nxt_bpa;
			bpc_ff <= nxt_bpc;
			rdat_ff <= nxt_rdat;
			ack_ff <= nxt_ack;
			abort_rec_ff <= nxt_abort_rec;
			width_ff <= nxt_width;
			state_ff <= nxt_state;
			pabt_ff <= nxt_pabt;
			dabt_ff <= nxt_dabt;
			cen_ff <= nxt_cen;
			idle_ff <= (nxt_state == MDBGC_HALT);
			fa_ff <= (nxt_state == MDBGC_HALT) && FORCED_MULTIPLE;
			at_ff <= (nxt_state == MDBGC_RUN) && MEM_ABORT_IN;
			it_ff <= (nxt_state == MDBGC_RUN) && IRQ_IN;
		end
	end
	// enable choice follows the state of the next cycle
	always_comb nxt_cen = (nxt_state == MDBGC_HALT) ? nxt_den : SYSTEM_CLOCK_ENABLE;
	assign ack_o_ff = ack_ff;
	assign WB_ACK_O = ack_o_ff;
	assign WB_DAT_O = rdat_ff;
	assign RETURNED_TEST_CLOCK = returned_test_clock_ff;
	assign DEBUG_CLOCK_ENABLE = den_ff;
	assign CORE_CLOCK_ENABLE = cen_ff;
	assign PREFETCH_ABORT = pabt_ff;
	assign DATA_ABORT = dabt_ff;
	assign DEBUG_ACK = idle_ff;
	assign MEM_IDLE = idle_ff;
	assign FORCED_ACCEPT = fa_ff;
	assign ABORT_TAKE = at_ff;
	assign IRQ_TAKE = it_ff;

	property p_den_pulse; den_ff |=> !den_ff; endproperty
	a_den_pulse: assert property (p_den_pulse) else $error("debug enable too long");
	property p_returned_test_clock_ack; $rose(den_ff) |=> returned_test_clock_ff; endproperty
	a_returned_test_clock_ack: assert property (p_returned_test_clock_ack) else $error("returned clock missing");
	property p_mon_pabt; PREFETCH_ABORT |-> monitor || $past(monitor); endproperty
	a_mon_pabt: assert property (p_mon_pabt) else $error("abort outside monitor");
	property p_abort_rec; (PREFETCH_ABORT || DATA_ABORT) |-> abort_rec_ff; endproperty
	a_abort_rec: assert property (p_abort_rec) else $error("abort not recorded");
	property p_sticky; (abort_rec_ff && !wr) |=> abort_rec_ff; endproperty
	a_sticky: assert property (p_sticky) else $error("abort record lost");
	property p_mon_nohalt; (state_ff == MDBGC_RUN) && monitor && !EXTERNAL_DEBUG_REQUEST
		|=> (state_ff == MDBGC_RUN); endproperty
	a_mon_nohalt: assert property (p_mon_nohalt) else $error("monitor mode halted");
	property p_idle; MEM_IDLE |-> !ABORT_TAKE && !IRQ_TAKE; endproperty
	a_idle: assert property (p_idle) else $error("abort taken while halted");
	property p_cen_halt; (state_ff == MDBGC_HALT) |-> (CORE_CLOCK_ENABLE == den_ff); endproperty
	a_cen_halt: assert property (p_cen_halt) else $error("wrong enable while halted");
	c_halt: cover property (@(posedge CORE_CLK) state_ff == MDBGC_HALT);
	c_pabt: cover property (@(posedge CORE_CLK) PREFETCH_ABORT);
	c_dabt: cover property (@(posedge CORE_CLK) DATA_ABORT);
	c_den: cover property (@(posedge CORE_CLK) den_ff);
endmodule : mdbgc_top
`default_nettype wire

// ### include/mdbgc_pkg.sv
// package of constants for the monitor debug and clocking block
// assumes a 25 MHz core clock and a classic wishbone register bus
package mdbgc_pkg;
	localparam int CORE_CLK_MHZ = 25;
	localparam logic [7:0] ADDR_DBG_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DBG_STAT = 8'h04;
	localparam logic [7:0] ADDR_WP_CTRL = 8'h08;
	localparam logic [7:0] ADDR_WP_ADDR = 8'h0C;
	localparam logic [7:0] ADDR_WP_MASK = 8'h10;
	localparam logic [7:0] ADDR_BP_ADDR = 8'h14;
	localparam logic [7:0] ADDR_BP_CTRL = 8'h18;
	localparam int CTRL_RT_BIT = 4;
	localparam int CTRL_STEP_BIT = 0;
	localparam int CTRL_XEN_BIT = 1;
	localparam int STAT_ABORT_BIT = 0;
	localparam int STAT_HALT_BIT = 1;
	localparam int STAT_WIDTH_BIT = 4;
	localparam int WPC_EN_BIT = 0;
	localparam int WPC_DIR_BIT = 1;
	localparam int WPC_DIRCHK_BIT = 2;
	localparam int WPC_SIZE_LSB = 3;
	localparam int WPC_SZCHK_BIT = 5;
	localparam int WPC_PRIV_BIT = 6;
	localparam int WPC_PRVCHK_BIT = 7;
	localparam int WPC_EXT_BIT = 8;
	localparam int WPC_EXTCHK_BIT = 9;
	localparam int WPC_DATA_BIT = 10;
	localparam int WPC_CHAIN_BIT = 11;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {
		MDBGC_RUN = 2'h1,
		MDBGC_HALT = 2'h2
	} mdbgc_state_t;
endpackage : mdbgc_pkg

// ### core/mdbgc_watch_unit.sv
// one comparator unit, address, size, direction, privilege and conditioner
// assumes inputs on the core clock and register writes flagged by the top
`timescale 1ns/10ps
`default_nettype none
module mdbgc_watch_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] ctrl,
	input wire logic [31:0] addr_val,
	input wire logic [31:0] addr_mask,
	input wire logic monitor,
	input wire logic reg_update,
	input wire logic access_valid,
	input wire logic [31:0] access_addr,
	input wire logic access_write,
	input wire logic [1:0] access_size,
	input wire logic access_priv,
	input wire logic conditioner,
	input wire logic data_match,
	output logic hit
);
	import mdbgc_pkg::*;
	logic hit_ff;
	logic nxt_hit;
	logic base;
	always_comb begin
		base = ctrl[WPC_EN_BIT] && access_valid
			&& (((access_addr ^ addr_val) & ~addr_mask) == 32'h0000_0000)
			&& (!ctrl[WPC_DIRCHK_BIT] || (access_write == ctrl[WPC_DIR_BIT]))
			&& (!ctrl[WPC_SZCHK_BIT] || (access_size == ctrl[WPC_SIZE_LSB +: 2]))
			&& (!ctrl[WPC_PRVCHK_BIT] || (access_priv == ctrl[WPC_PRIV_BIT]))
			&& (!ctrl[WPC_EXTCHK_BIT] || (conditioner == ctrl[WPC_EXT_BIT]));
		// data value and chaining ignored in monitor mode
		if (!monitor && ctrl[WPC_DATA_BIT])
			base = base && data_match;
		if (monitor && ctrl[WPC_CHAIN_BIT])
			base = base;
		// register update during an access hides this unit's matches
		nxt_hit = base && !(reg_update && access_valid);
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hit_ff <= 1'b0;
		else
			hit_ff <= nxt_hit;
	end
	assign hit = hit_ff;
	property p_upd_sup;
		@(posedge clk) disable iff (!rst_n) (reg_update && access_valid) |=> !hit_ff;
	endproperty
	a_upd_sup: assert property (p_upd_sup) else $error("match during register update");
endmodule : mdbgc_watch_unit
`default_nettype wire

// ### test/mdbgc_agent_model.sv
// off-chip agent model: steps the test clock, waits for each returned edge
// assumes start pulses from the bench; the test clock stands still between runs
`timescale 1ns/10ps
`default_nettype none
module mdbgc_agent_model #(
	parameter int HALF_NS = 160
) (
	input wire logic start,
	input wire logic [7:0] edges,
	input wire logic returned_test_clock,
	output logic test_clk,
	output logic done
);
	realtime t0;
	int w;
	initial begin
		test_clk = 1'h0;
		done = 1'h0;
	end
	always @(posedge start) begin
		done = 1'h0;
		#3;
		for (int i = 0; i < int'(edges); i++) begin
			t0 = $realtime;
			test_clk = ~test_clk;
			w = 0;
			// next edge once the returned clock has followed or 200 polls of 7 ns have passed
			while (returned_test_clock !== test_clk && w < 200) begin
				#7;
				w++;
			end
			if ($realtime - t0 < HALF_NS) #(HALF_NS - ($realtime - t0));
		end
		done = 1'h1;
	end
endmodule : mdbgc_agent_model
`default_nettype wire

// ### test/mdbgc_top_tb.sv
// bench for mdbgc_top: wishbone master, table of monitor watch cases, hand tests
// assumes mdbgc_agent_model drives the test clock
`timescale 1ns/10ps
`default_nettype none
module mdbgc_top_tb;
	import mdbgc_pkg::*;
	typedef struct {logic [31:0] wpc; logic [31:0] ad; logic wr; logic [1:0] sz;
		logic pv; logic cn; logic vm; logic hit;} mdbgc_row_t;
	logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, tck, ret_clk;
	logic dce, sce = 1'h1, cce, edr = 1'h0, ebk = 1'h0, ewp = 1'h0, cond = 1'h0, iv = 1'h0;
	logic ipv = 1'h0, iw = 1'h0, dv = 1'h0, dwr = 1'h0, dpv = 1'h0, dvm = 1'h0, step = 1'h0;
	logic fm = 1'h0, cexit = 1'h0, mab = 1'h0, irq = 1'h0, go = 1'h0, done;
	logic pab, dab, dack, idle, facc, atake, itake;
	logic [7:0] adr = 8'h00, nedg = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [1:0] dsz = 2'h0;
	logic [31:0] wdat = 32'h0, rdat, rd, iad = 32'h0, dad = 32'h0;
	int fails = 0, samples_checked = 0, cycles = 0, dcnt = 0, ccnt = 0, pcnt = 0, acnt = 0;
	int a0, p0, d0, c0;
	mdbgc_row_t rows[9] = '{
		'{32'h001, 32'h1000, 1'h0, 2'h2, 1'h0, 1'h0, 1'h0, 1'h1},
		'{32'h007, 32'h1000, 1'h0, 2'h2, 1'h0, 1'h0, 1'h0, 1'h0},
		'{32'h007, 32'h1000, 1'h1, 2'h2, 1'h0, 1'h0, 1'h0, 1'h1},
		'{32'h031, 32'h1000, 1'h0, 2'h1, 1'h0, 1'h0, 1'h0, 1'h0},
		'{32'h0C1, 32'h1000, 1'h0, 2'h2, 1'h0, 1'h0, 1'h0, 1'h0},
		'{32'h301, 32'h1000, 1'h0, 2'h2, 1'h0, 1'h1, 1'h0, 1'h1},
		'{32'h401, 32'h1000, 1'h0, 2'h2, 1'h0, 1'h0, 1'h0, 1'h1},
		'{32'h801, 32'h1000, 1'h0, 2'h2, 1'h0, 1'h0, 1'h0, 1'h1},
		'{32'h001, 32'h2000, 1'h0, 2'h2, 1'h0, 1'h0, 1'h0, 1'h0}};
	mdbgc_top dut (.CORE_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.TEST_CLK(tck), .RETURNED_TEST_CLOCK(ret_clk), .DEBUG_CLOCK_ENABLE(dce),
		.SYSTEM_CLOCK_ENABLE(sce), .CORE_CLOCK_ENABLE(cce), .EXTERNAL_DEBUG_REQUEST(edr),
		.EXTERNAL_BREAKPOINT_INPUT(ebk), .EXTERNAL_WATCHPOINT_INPUT(ewp),
		.EXTERNAL_WATCH_CONDITIONER(cond), .INSTR_VALID(iv), .INSTR_ADDR(iad),
		.INSTR_PRIVILEGE_INDICATOR(ipv), .INSTR_WIDTH_INDICATOR(iw), .DATA_VALID(dv),
		.DATA_ADDR(dad), .DATA_WRITE(dwr), .DATA_ACCESS_SIZE(dsz),
		.DATA_PRIVILEGE_INDICATOR(dpv), .DATA_VALUE_MATCH(dvm), .STEP_DONE(step),
		.FORCED_MULTIPLE(fm), .CORE_EXIT_DEBUG(cexit), .MEM_ABORT_IN(mab), .IRQ_IN(irq),
		.PREFETCH_ABORT(pab), .DATA_ABORT(dab), .DEBUG_ACK(dack), .MEM_IDLE(idle),
		.FORCED_ACCEPT(facc), .ABORT_TAKE(atake), .IRQ_TAKE(itake));
	mdbgc_agent_model agent (.start(go), .edges(nedg), .returned_test_clock(ret_clk),
		.test_clk(tck), .done(done));
	always #20 clk = ~clk;
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	// pulse counters settle by nba so readers see whole-cycle counts
	always @(posedge clk) begin
		cycles <= cycles + 1;
		dcnt <= dcnt + int'(dce === 1'h1);
		ccnt <= ccnt + int'(cce === 1'h1);
		pcnt <= pcnt + int'(pab === 1'h1);
		acnt <= acnt + int'(dab === 1'h1);
		if (cycles == 20000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 40);
		if (n >= 40) fails++;
		rd = rdat;
		{cyc, stb, we} <= 3'h0;
	endtask : wb
	task automatic pulse_data(input mdbgc_row_t r);
		@(posedge clk);
		{dv, dad, dwr, dsz, dpv, cond, dvm} <= {1'h1, r.ad, r.wr, r.sz, r.pv, r.cn, r.vm};
		@(posedge clk);
		dv <= 1'h0;
		repeat (5) @(posedge clk);
	endtask : pulse_data
	task automatic link(input logic [7:0] n);
		int w;
		w = 0;
		@(posedge clk);
		{nedg, go} <= {n, 1'h1};
		repeat (2) @(posedge clk);
		go <= 1'h0;
		while (done !== 1'h1 && w < 2000) begin
			@(posedge clk);
			w++;
		end
		repeat (8) @(posedge clk);
	endtask : link
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		check({ack, dab, pab, dack, idle, dce, ret_clk}, 32'h0);
		wb(ADDR_DBG_STAT, 1'h0, 32'h0);
		check(rd, RST_ZERO);
		wb(8'h1C, 1'h0, 32'h0);
		check(rd, UNMAPPED_READ);
		$display("test reset done");
		// monitor mode, external enable bit set but gated off by monitor; no debug request here
		wb(ADDR_WP_ADDR, 1'h1, 32'h1000);
		wb(ADDR_WP_MASK, 1'h1, 32'h0);
		wb(ADDR_DBG_CTRL, 1'h1, 32'h12);
		foreach (rows[i]) begin
			wb(ADDR_WP_CTRL, 1'h1, rows[i].wpc);
			a0 = acnt;
			pulse_data(rows[i]);
			check(32'(acnt - a0), {31'h0, rows[i].hit});
		end
		$display("test watch table done");
		wb(ADDR_DBG_STAT, 1'h1, 32'h1);
		wb(ADDR_WP_CTRL, 1'h1, 32'h1);
		pulse_data(rows[0]);
		repeat (2) begin
			wb(ADDR_DBG_STAT, 1'h0, 32'h0);
			check(rd & 32'h3, 32'h1);
		end
		wb(ADDR_DBG_STAT, 1'h1, 32'h1);
		wb(ADDR_DBG_STAT, 1'h0, 32'h0);
		check(rd & 32'h1, 32'h0);
		// matching access in the very cycle the unit is rewritten
		a0 = acnt;
		@(posedge clk);
		{cyc, stb, we, adr, wdat, dv, dad} <= {3'h7, ADDR_WP_ADDR, 32'h1000, 1'h1, 32'h1000};
		@(posedge clk);
		dv <= 1'h0;
		while (ack !== 1'h1) @(posedge clk);
		{cyc, stb, we} <= 3'h0;
		repeat (5) @(posedge clk);
		check(32'(acnt - a0), 32'h0);
		wb(ADDR_WP_CTRL, 1'h1, 32'h0);
		wb(ADDR_WP_MASK, 1'h1, 32'hF000);
		wb(ADDR_WP_CTRL, 1'h1, 32'h1);
		a0 = acnt;
		pulse_data(rows[8]);
		check(32'(acnt - a0), 32'h0);
		$display("test abort record done");
		wb(ADDR_DBG_CTRL, 1'h1, 32'h13);
		wb(ADDR_BP_ADDR, 1'h1, 32'h3000);
		wb(ADDR_BP_CTRL, 1'h1, 32'h1);
		{a0, p0} = {acnt, pcnt};
		@(posedge clk);
		{iv, iad, ebk, ewp, step} <= {1'h1, 32'h3000, 3'h7};
		@(posedge clk);
		{iv, ebk, ewp, step} <= 4'h0;
		repeat (6) @(posedge clk);
		check(32'(pcnt - p0), 32'h1);
		check(32'(acnt - a0), 32'h0);
		check({31'h0, dack}, 32'h0);
		$display("test breakpoint done");
		wb(ADDR_BP_CTRL, 1'h1, 32'h0);
		wb(ADDR_DBG_CTRL, 1'h1, 32'h0);
		@(posedge clk);
		{edr, iw} <= 2'h3;
		repeat (6) @(posedge clk);
		{edr, iw} <= 2'h0;
		check({30'h0, dack, idle}, 32'h3);
		wb(ADDR_DBG_STAT, 1'h0, 32'h0);
		check(rd & 32'h12, 32'h12);
		{mab, irq, fm} <= 3'h7;
		repeat (3) @(posedge clk);
		check({29'h0, atake, itake, facc}, 32'h1);
		{d0, c0} = {dcnt, ccnt};
		link(8'h04);
		check(32'(dcnt - d0), 32'h2);
		check(32'(ccnt - c0), 32'h2);
		check({31'h0, ret_clk}, {31'h0, tck});
		{mab, irq, fm, cexit} <= 4'h1;
		repeat (2) @(posedge clk);
		cexit <= 1'h0;
		repeat (3) @(posedge clk);
		check({30'h0, dack, cce}, 32'h1);
		$display("test halt done");
		{sce, irq, mab} <= 3'h3;
		repeat (3) @(posedge clk);
		check({29'h0, cce, itake, atake}, 32'h3);
		{sce, irq, mab} <= 3'h4;
		d0 = dcnt;
		link(8'h06);
		check(32'(dcnt - d0), 32'h3);
		$display("test run link done");
		wb(ADDR_WP_CTRL, 1'h1, 32'h401);
		pulse_data(rows[6]);
		check({31'h0, dack}, 32'h0);
		wb(ADDR_WP_CTRL, 1'h1, 32'h1);
		pulse_data(rows[0]);
		check({31'h0, dack}, 32'h1);
		$display("test halt watch done");
		print_verdict();
	end
endmodule : mdbgc_top_tb
`default_nettype wire
